// ===== rtl/tilt_server_consts.vh
// Register map, field positions, defaults and timing for the tilt server
`ifndef TILT_SERVER_CONSTS_VH
`define TILT_SERVER_CONSTS_VH
// Register addresses
`define ADDR_TILT_X 16'h0001
`define ADDR_TILT_Y 16'h0002
`define ADDR_SIGNED_ANGLE 16'h0003
`define ADDR_FULL_ANGLE 16'h0004
`define ADDR_TEMPERATURE 16'h0005
`define ADDR_STATUS 16'h0006
`define ADDR_LINE_RATE 16'h000A
`define ADDR_PARITY 16'h000B
`define ADDR_STOP_BIT 16'h000C
`define ADDR_NODE_ID 16'h000D
`define ADDR_TERMINATION 16'h000E
`define ADDR_SMOOTHING 16'h000F
`define ADDR_X_ZERO 16'h0014
`define ADDR_X_PRESET 16'h0015
`define ADDR_X_OFFSET 16'h0016
`define ADDR_X_INVERT 16'h0017
`define ADDR_X_LIMIT 16'h0018
`define ADDR_Y_ZERO 16'h001E
`define ADDR_Y_PRESET 16'h001F
`define ADDR_Y_OFFSET 16'h0020
`define ADDR_Y_INVERT 16'h0021
`define ADDR_Y_LIMIT 16'h0022
`define ADDR_PART_ID 16'h0028
`define ADDR_SAVE_CFG 16'h0032
`define ADDR_RESTART 16'h0034
`define ADDR_LAST 16'h0034
// Reset values
`define RST_LINE_RATE 16'h0004
`define RST_PARITY 16'h0002
`define RST_STOP_BIT 16'h0001
`define RST_NODE_ID 16'h0064
`define RST_TERMINATION 16'h0001
`define RST_SMOOTHING 16'h0064
`define RST_INVERT 16'h0001
`define RST_X_LIMIT 16'h001E
`define RST_Y_LIMIT_1AX 16'h00B4
`define RST_Y_LIMIT_2AX 16'h001E
`define PART_ID_VALUE 16'h1234
// Codes
`define LINE_RATE_MAX 16'h0005
`define INVERT_OFF 16'h0001
`define INVERT_ON 16'h0002
`define SAVE_PATTERN 16'h5354
`define RESTART_PATTERN 16'h5253
`define FN_READ 8'h03
`define FN_WRITE 8'h06
`define FN_EXC_FLAG 8'h80
`define EXC_FUNCTION 8'h01
`define EXC_ADDRESS 8'h02
`define EXC_VALUE 8'h03
`define CRC_POLY 16'hA001
`define CRC_INIT 16'hFFFF
`define DEG_TO_HUNDREDTHS 32'd100
`define FULL_CIRCLE 17'd36000
// Status bits
`define ST_ERROR 0
`define ST_SINGLE_AXIS 1
`define ST_X_HIGH 10
// Frame timing: 3.5 characters of 11 bits
`define CLK_HZ 200000000
`define GAP_BITS_X2 77
`endif

// ===== rtl/tilt_modbus_server.v
// Modbus RTU register server for a tilt-sensing unit
`timescale 1ns/1ps
`include "tilt_server_consts.vh"

module tilt_modbus_server (
    input wire clk,
    input wire reset,
    input wire single_axis,
    input wire [15:0] raw_angle_x,
    input wire [15:0] raw_angle_y,
    input wire [15:0] temp_celsius,
    input wire sensor_fault,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire bit_tick,
    input wire tx_ready,
    output reg tx_valid,
    output reg [7:0] tx_byte,
    output reg [15:0] active_rate_code,
    output reg [15:0] active_parity_code,
    output reg [15:0] active_stop_code,
    output reg save_pulse,
    output reg restart_pulse
);
    localparam S_RX = 3'd0;
    localparam S_CHECK = 3'd1;
    localparam S_EXEC = 3'd2;
    localparam S_TX = 3'd3;
    localparam S_TXCRC = 3'd4;
    localparam S_CRCSTEP = 3'd5;

    reg [2:0] state;
    reg [7:0] rx_buf [0:7];
    reg [3:0] rx_cnt;
    reg [6:0] gap_cnt;
    reg [15:0] crc;
    reg [3:0] crc_bit;
    reg [7:0] tx_buf [0:4];
    reg [6:0] tx_len;
    reg [6:0] tx_idx;
    reg [15:0] rd_addr;
    reg tx_crc_hi;
    reg restart_after;
    reg [15:0] line_rate_code, parity_code, stop_bit_code, node_id;
    reg [15:0] line_termination, smoothing, x_offset_value, y_offset_value;
    reg [15:0] x_invert, y_invert, x_limit, y_limit, active_node;
    reg y_limit_set;
    wire [15:0] req_addr = {rx_buf[2], rx_buf[3]};
    wire [15:0] req_data = {rx_buf[4], rx_buf[5]};
    wire [15:0] frame_crc = {rx_buf[7], rx_buf[6]};
    wire [16:0] last_addr = {1'b0, req_addr} + {1'b0, req_data} - 17'd1;

    // Inversion applied before offset, as preset math expects it
    wire [15:0] inv_x = (x_invert == `INVERT_ON) ? -raw_angle_x : raw_angle_x;
    wire [15:0] inv_y = (y_invert == `INVERT_ON) ? -raw_angle_y : raw_angle_y;
    wire [15:0] cor_x = inv_x + x_offset_value;
    wire [15:0] cor_y = inv_y + y_offset_value;
    // Limit in hundredths of a degree
    wire [15:0] x_lim_h = x_limit * 16'h0064;
    wire x_high = $signed(cor_x) > $signed(x_lim_h);
    wire x_low = $signed(cor_x) < -$signed(x_lim_h);
    // Clamp only the signed form; the full circle keeps the true value
    wire [15:0] signed_ang = x_high ? x_lim_h :
        (x_low ? -x_lim_h : cor_x);
    wire [16:0] wrap = {1'b0, cor_x} + `FULL_CIRCLE;
    wire [15:0] full_ang = cor_x[15] ? wrap[15:0] : cor_x;
    wire [15:0] status_word = ({15'h0000, sensor_fault | x_high | x_low}
        << `ST_ERROR) | ({15'h0000, single_axis} << `ST_SINGLE_AXIS)
        | ({15'h0000, x_high} << `ST_X_HIGH);

    // Register read mux; unknown and write-only addresses read zero
    reg [15:0] rd_data;
    always @* begin
        case (rd_addr)
            `ADDR_TILT_X: rd_data = single_axis ? 16'h0000 : cor_x;
            `ADDR_TILT_Y: rd_data = single_axis ? 16'h0000 : cor_y;
            `ADDR_SIGNED_ANGLE: rd_data = signed_ang;
            `ADDR_FULL_ANGLE: rd_data = full_ang;
            `ADDR_TEMPERATURE: rd_data = temp_celsius;
            `ADDR_STATUS: rd_data = status_word;
            `ADDR_LINE_RATE: rd_data = line_rate_code;
            `ADDR_PARITY: rd_data = parity_code;
            `ADDR_STOP_BIT: rd_data = stop_bit_code;
            `ADDR_NODE_ID: rd_data = node_id;
            `ADDR_TERMINATION: rd_data = line_termination;
            `ADDR_SMOOTHING: rd_data = smoothing;
            `ADDR_X_OFFSET: rd_data = x_offset_value;
            `ADDR_X_INVERT: rd_data = x_invert;
            `ADDR_X_LIMIT: rd_data = x_limit;
            `ADDR_Y_OFFSET: rd_data = y_offset_value;
            `ADDR_Y_INVERT: rd_data = y_invert;
            `ADDR_Y_LIMIT: rd_data = y_limit_set ? y_limit :
                (single_axis ? `RST_Y_LIMIT_1AX : `RST_Y_LIMIT_2AX);
            `ADDR_PART_ID: rd_data = `PART_ID_VALUE; // Arbitrary value
            default: rd_data = 16'h0000;
        endcase
    end

    // Write address check: mapped writable registers
    reg wr_mapped;
    reg wr_value_ok;
    always @* begin
        wr_value_ok = 1'b1;
        case (req_addr)
            `ADDR_LINE_RATE: begin
                wr_mapped = 1'b1;
                wr_value_ok = req_data <= `LINE_RATE_MAX;
            end
            `ADDR_X_INVERT, `ADDR_Y_INVERT: begin
                wr_mapped = 1'b1;
                wr_value_ok = (req_data == `INVERT_ON) ||
                    (req_data == `INVERT_OFF);
            end
            `ADDR_SAVE_CFG: begin
                wr_mapped = 1'b1;
                wr_value_ok = req_data == `SAVE_PATTERN;
            end
            `ADDR_RESTART: begin
                wr_mapped = 1'b1;
                wr_value_ok = req_data == `RESTART_PATTERN;
            end
            `ADDR_PARITY, `ADDR_STOP_BIT, `ADDR_NODE_ID, `ADDR_TERMINATION,
            `ADDR_SMOOTHING, `ADDR_X_ZERO, `ADDR_X_PRESET, `ADDR_X_LIMIT,
            `ADDR_Y_ZERO, `ADDR_Y_PRESET, `ADDR_Y_LIMIT: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    // Byte to transmit from header buffer or register words
    reg [7:0] tx_pick;
    always @* begin
        if (rx_buf[1] == `FN_READ && tx_buf[1] == `FN_READ && tx_idx >= 7'd3)
            tx_pick = tx_idx[0] ? rd_data[15:8] : rd_data[7:0];
        else
            tx_pick = tx_buf[tx_idx[2:0]];
    end

    // Main sequencer: receive, check, execute, answer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= S_RX;
            rx_cnt <= 4'h0;
            gap_cnt <= 7'h00;
            crc <= `CRC_INIT;
            crc_bit <= 4'h0;
            tx_len <= 7'h00;
            tx_idx <= 7'h00;
            rd_addr <= 16'h0000;
            tx_crc_hi <= 1'b0;
            restart_after <= 1'b0;
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
            save_pulse <= 1'b0;
            restart_pulse <= 1'b0;
            line_rate_code <= `RST_LINE_RATE;
            parity_code <= `RST_PARITY;
            stop_bit_code <= `RST_STOP_BIT;
            node_id <= `RST_NODE_ID;
            active_node <= `RST_NODE_ID;
            active_rate_code <= `RST_LINE_RATE;
            active_parity_code <= `RST_PARITY;
            active_stop_code <= `RST_STOP_BIT;
            line_termination <= `RST_TERMINATION;
            smoothing <= `RST_SMOOTHING;
            x_offset_value <= 16'h0000;
            y_offset_value <= 16'h0000;
            x_invert <= `RST_INVERT;
            y_invert <= `RST_INVERT;
            x_limit <= `RST_X_LIMIT;
            y_limit <= 16'h0000;
            y_limit_set <= 1'b0;
            tx_buf[0] <= 8'h00;
            tx_buf[1] <= 8'h00;
            tx_buf[2] <= 8'h00;
            tx_buf[3] <= 8'h00;
            tx_buf[4] <= 8'h00;
        end else begin
            save_pulse <= 1'b0;
            restart_pulse <= 1'b0;
            case (state)
                S_RX: begin
                    if (rx_valid) begin
                        gap_cnt <= 7'h00;
                        if (rx_cnt < 4'd8)
                            rx_buf[rx_cnt[2:0]] <= rx_byte;
                        if (rx_cnt != 4'hF)
                            rx_cnt <= rx_cnt + 4'd1;
                    end else if (bit_tick && rx_cnt != 4'h0) begin
                        // Half-bit ticks: 77 halves is 3.5 chars
                        if (gap_cnt == `GAP_BITS_X2 - 1) begin
                            gap_cnt <= 7'h00;
                            state <= S_CHECK;
                            crc <= `CRC_INIT;
                            tx_idx <= 7'h00;
                            crc_bit <= 4'h0;
                        end else
                            gap_cnt <= gap_cnt + 7'd1;
                    end
                end
                S_CHECK: begin
                    // Bitwise CRC over the first six bytes
                    if (rx_cnt != 4'd8 || rx_buf[0] != active_node[7:0]) begin
                        rx_cnt <= 4'h0;
                        state <= S_RX;
                    end else if (tx_idx == 7'd6) begin
                        if (crc == frame_crc)
                            state <= S_EXEC;
                        else begin
                            rx_cnt <= 4'h0;
                            state <= S_RX;
                        end
                    end else begin
                        // Steps 1 to 8 each shift; the eighth moves on
                        if (crc_bit == 4'd0)
                            crc <= crc ^ {8'h00, rx_buf[tx_idx[2:0]]};
                        else
                            crc <= crc[0] ? ((crc >> 1) ^ `CRC_POLY)
                                : (crc >> 1);
                        crc_bit <= (crc_bit == 4'd8) ? 4'd0 : crc_bit + 4'd1;
                        if (crc_bit == 4'd8)
                            tx_idx <= tx_idx + 7'd1;
                    end
                end
                S_EXEC: begin
                    tx_buf[0] <= rx_buf[0];
                    tx_buf[1] <= rx_buf[1];
                    tx_idx <= 7'h00;
                    crc <= `CRC_INIT;
                    crc_bit <= 4'h0;
                    rx_cnt <= 4'h0;
                    state <= S_TX;
                    if (rx_buf[1] == `FN_READ) begin
                        if (req_data == 16'h0000 || last_addr >
                            {1'b0, `ADDR_LAST}) begin
                            tx_buf[1] <= rx_buf[1] | `FN_EXC_FLAG;
                            tx_buf[2] <= `EXC_ADDRESS;
                            tx_len <= 7'd3;
                        end else begin
                            tx_buf[2] <= {req_data[6:0], 1'b0};
                            rd_addr <= req_addr;
                            tx_len <= {req_data[5:0], 1'b0} + 7'd3;
                        end
                    end else if (rx_buf[1] == `FN_WRITE) begin
                        tx_buf[2] <= rx_buf[2];
                        tx_buf[3] <= rx_buf[3];
                        tx_buf[4] <= rx_buf[4];
                        tx_len <= 7'd6;
                        if (!wr_mapped) begin
                            tx_buf[1] <= rx_buf[1] | `FN_EXC_FLAG;
                            tx_buf[2] <= `EXC_ADDRESS;
                            tx_len <= 7'd3;
                        end else if (!wr_value_ok) begin
                            tx_buf[1] <= rx_buf[1] | `FN_EXC_FLAG;
                            tx_buf[2] <= `EXC_VALUE;
                            tx_len <= 7'd3;
                        end else begin
                            case (req_addr)
                                `ADDR_LINE_RATE: line_rate_code <= req_data;
                                `ADDR_PARITY: parity_code <= req_data;
                                `ADDR_STOP_BIT: stop_bit_code <= req_data;
                                `ADDR_NODE_ID: node_id <= req_data;
                                `ADDR_TERMINATION: line_termination <= req_data;
                                `ADDR_SMOOTHING: smoothing <= req_data;
                                `ADDR_X_ZERO: x_offset_value <= -inv_x;
                                `ADDR_X_PRESET:
                                    x_offset_value <= req_data - inv_x;
                                `ADDR_Y_ZERO: y_offset_value <= -inv_y;
                                `ADDR_Y_PRESET:
                                    y_offset_value <= req_data - inv_y;
                                `ADDR_X_INVERT: x_invert <= req_data;
                                `ADDR_Y_INVERT: y_invert <= req_data;
                                `ADDR_X_LIMIT: x_limit <= req_data;
                                `ADDR_Y_LIMIT: begin
                                    y_limit <= req_data;
                                    y_limit_set <= 1'b1;
                                end
                                `ADDR_SAVE_CFG: save_pulse <= 1'b1;
                                `ADDR_RESTART: restart_after <= 1'b1;
                                default: save_pulse <= 1'b0;
                            endcase
                        end
                    end else begin
                        tx_buf[1] <= rx_buf[1] | `FN_EXC_FLAG;
                        tx_buf[2] <= `EXC_FUNCTION;
                        tx_len <= 7'd3;
                    end
                end
                S_TX: begin
                    // Present a byte, fold it into the check on handshake
                    if (!tx_valid) begin
                        if (tx_idx == tx_len) begin
                            tx_crc_hi <= 1'b0;
                            tx_byte <= crc[7:0];
                            tx_valid <= 1'b1;
                            state <= S_TXCRC;
                        end else begin
                            tx_byte <= (tx_buf[1] == `FN_WRITE &&
                                tx_idx == 7'd5) ? rx_buf[5] : tx_pick;
                            tx_valid <= 1'b1;
                        end
                    end else if (tx_ready) begin
                        tx_valid <= 1'b0;
                        crc <= crc ^ {8'h00, tx_byte};
                        crc_bit <= 4'd1;
                        state <= S_CRCSTEP;
                    end
                end
                S_CRCSTEP: begin
                    crc <= crc[0] ? ((crc >> 1) ^ `CRC_POLY) : (crc >> 1);
                    if (crc_bit == 4'd8) begin
                        crc_bit <= 4'h0;
                        tx_idx <= tx_idx + 7'd1;
                        if (tx_idx[0] == 1'b0 && tx_idx >= 7'd4)
                            rd_addr <= rd_addr + 16'd1;
                        state <= S_TX;
                    end else
                        crc_bit <= crc_bit + 4'd1;
                end
                S_TXCRC: begin
                    if (tx_ready) begin
                        if (!tx_crc_hi) begin
                            tx_crc_hi <= 1'b1;
                            tx_byte <= crc[15:8];
                        end else begin
                            tx_valid <= 1'b0;
                            state <= S_RX;
                            if (restart_after) begin
                                // Stored settings take effect after echo
                                restart_after <= 1'b0;
                                restart_pulse <= 1'b1;
                                active_node <= node_id;
                                active_rate_code <= line_rate_code;
                                active_parity_code <= parity_code;
                                active_stop_code <= stop_bit_code;
                            end
                        end
                    end
                end
                default: state <= S_RX;
            endcase
        end
    end
endmodule // tilt_modbus_server

// ===== testbench/tilt_server_props.sv
// Port-level concurrent checks for the tilt register server
`timescale 1ns/1ps
`include "tilt_server_consts.vh"
module tilt_server_props (
    input wire clk,
    input wire reset,
    input wire single_axis,
    input wire [15:0] raw_angle_x,
    input wire [15:0] raw_angle_y,
    input wire [15:0] temp_celsius,
    input wire sensor_fault,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire bit_tick,
    input wire tx_ready,
    input wire tx_valid,
    input wire [7:0] tx_byte,
    input wire [15:0] active_rate_code,
    input wire [15:0] active_parity_code,
    input wire [15:0] active_stop_code,
    input wire save_pulse,
    input wire restart_pulse
);
    localparam int GAP = `GAP_BITS_X2;
    logic [7:0] quiet;
    // Half-bit ticks since the last received byte, saturating
    always_ff @(posedge clk or posedge reset) begin
        if (reset) quiet <= 8'hFF;
        else if (rx_valid) quiet <= 8'h00;
        else if (bit_tick && quiet != 8'hFF) quiet <= quiet + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_offer_waiting; tx_valid && !tx_ready; endsequence
    sequence s_offer_kept; tx_valid && $stable(tx_byte); endsequence
    sequence s_echo_done; !tx_valid; endsequence
    property p_offer_held; s_offer_waiting |=> s_offer_kept; endproperty
    property p_after_gap; $rose(tx_valid) |-> quiet >= GAP; endproperty
    property p_rate_legal; active_rate_code <= `LINE_RATE_MAX; endproperty
    property p_codes_restart;
        ($changed(active_rate_code) || $changed(active_parity_code) ||
         $changed(active_stop_code)) |-> restart_pulse || $past(restart_pulse);
    endproperty
    property p_defaults;
        $fell(reset) |-> active_rate_code == 16'h0004 && !tx_valid &&
            active_parity_code == 16'h0002 && active_stop_code == 16'h0001;
    endproperty
    property p_restart_late; restart_pulse |-> s_echo_done ##1 !restart_pulse;
    endproperty
    property p_save_framed; save_pulse |-> quiet >= GAP ##1 !save_pulse;
    endproperty
    property p_one_pulse; !(save_pulse && restart_pulse); endproperty
    property p_released; $fell(tx_valid) |-> $past(tx_ready); endproperty
    a_offer_held: assert property (p_offer_held)
        else $error("reply byte changed before acceptance");
    a_after_gap: assert property (p_after_gap)
        else $error("reply began before the frame gap");
    a_rate_legal: assert property (p_rate_legal)
        else $error("line rate code in force above five");
    a_codes_restart: assert property (p_codes_restart)
        else $error("line settings changed without restart");
    a_defaults: assert property (p_defaults)
        else $error("line settings not at defaults after reset");
    a_restart_late: assert property (p_restart_late)
        else $error("restart while reply still offered");
    a_save_framed: assert property (p_save_framed)
        else $error("save pulse outside a completed frame");
    a_one_pulse: assert property (p_one_pulse)
        else $error("save and restart pulses together");
    a_released: assert property (p_released)
        else $error("reply byte withdrawn without acceptance");
endmodule // tilt_server_props

// ===== testbench/modbus_master_model.sv
// Bus master model: frames requests and collects reply bytes
`timescale 1ns/1ps
module modbus_master_model (
    input wire clk,
    input wire stall,
    input wire tx_valid,
    input wire [7:0] tx_byte,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic bit_tick,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic corrupt = 1'b0;
    logic [1:0] div = 2'b00;
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        bit_tick = 1'b0;
        tx_ready = 1'b0;
    end
    // Half-bit tick every 4 cycles; a stalled ready is low half the time
    always @(negedge clk) begin
        div <= div + 2'b01;
        bit_tick <= (div == 2'b11);
        tx_ready <= !stall || div[1];
    end
    // Take each reply byte on the accepting edge
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_byte);
    end
    // Check value over a frame, shift right with reflected polynomial
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // Bytes 4 cycles apart; idle data line shows the inverse of the last
    task automatic send(input logic [7:0] f[$]);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, corrupt};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(negedge clk) rx_valid = 1'b1;
            rx_byte = f[i];
            @(negedge clk) rx_valid = 1'b0;
            rx_byte = ~f[i];
            repeat (2) @(negedge clk);
        end
    endtask
endmodule // modbus_master_model

// ===== testbench/tilt_modbus_server_tb.sv
// Self-checking bench for the tilt register server
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", w, e, g); end end
module tilt_modbus_server_tb;
    logic clk, reset, single_axis, sensor_fault, stall;
    logic [15:0] raw_angle_x, raw_angle_y, temp_celsius;
    wire rx_valid, bit_tick, tx_ready, tx_valid, save_pulse, restart_pulse;
    wire [7:0] rx_byte, tx_byte;
    wire [15:0] active_rate_code, active_parity_code, active_stop_code;
    int errors = 0, n_checks = 0, n_save = 0, n_restart = 0, cyc = 0;
    tilt_modbus_server u_dut (.clk(clk), .reset(reset),
        .single_axis(single_axis), .raw_angle_x(raw_angle_x),
        .raw_angle_y(raw_angle_y), .temp_celsius(temp_celsius),
        .sensor_fault(sensor_fault), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .bit_tick(bit_tick), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .active_rate_code(active_rate_code),
        .active_parity_code(active_parity_code),
        .active_stop_code(active_stop_code), .save_pulse(save_pulse),
        .restart_pulse(restart_pulse));
    modbus_master_model u_m (.clk(clk), .stall(stall), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .bit_tick(bit_tick), .tx_ready(tx_ready));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Verdict; also reached when the cycle ceiling cuts a hang short
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Pulse counts and the cycle ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_save <= n_save + int'(save_pulse);
        n_restart <= n_restart + int'(restart_pulse);
        if (cyc == 80000) begin
            errors++;
            wrap_up();
        end
    end
    // One request, then n expected reply bytes plus check value; n=0 silent
    task automatic xfer(input logic [47:0] req, input logic [119:0] rsp,
                        input int n);
        logic [7:0] q[$];
        logic [7:0] e[$];
        logic [15:0] c;
        int k;
        for (int i = 5; i >= 0; i--) q.push_back(req[i*8 +: 8]);
        for (int i = n - 1; i >= 0; i--) e.push_back(rsp[i*8 +: 8]);
        c = u_m.crc16(e);
        if (n > 0) e = {e, c[7:0], c[15:8]};
        u_m.send(q);
        k = 0;
        while (u_m.got.size() < e.size() && k < 3000) begin
            @(posedge clk);
            k++;
        end
        // Long enough for any stray reply to show
        repeat (400) @(posedge clk);
        `CHK("reply length", e.size(), u_m.got.size())
        foreach (e[i])
            if (i < u_m.got.size()) `CHK("reply byte", e[i], u_m.got[i])
        u_m.got.delete();
    endtask
    initial begin
        reset = 1'b1;
        single_axis = 1'b1;
        sensor_fault = 1'b0;
        stall = 1'b0;
        raw_angle_x = 16'hF871;
        raw_angle_y = 16'h0123;
        temp_celsius = 16'h001C;
        repeat (12) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        xfer(48'h640300060001, 40'h6403020002, 5);
        xfer(48'h640300010005, 104'h64030A00000000F8718511001C,
            13);
        xfer(48'h6406000F012C, 48'h6406000F012C, 6);
        xfer(48'h6406000A0006, 24'h648603, 3);
        xfer(48'h640600170003, 24'h648603, 3);
        xfer(48'h6406000A0003, 48'h6406000A0003, 6);
        `CHK("rate before restart", 16'h0004, active_rate_code)
        xfer(48'h640600DD0020, 24'h648602, 3);
        xfer(48'h6406000D0020, 48'h6406000D0020, 6);
        xfer(48'h640400010001, 24'h648401, 3);
        xfer(48'h64030028000F, 24'h648302, 3);
        @(negedge clk) raw_angle_x = 16'h0791;
        xfer(48'h640300030002, 56'h64030407910791, 7);
        xfer(48'h640600170002, 48'h640600170002, 6);
        @(negedge clk) raw_angle_x = 16'hF872; // Reads +19.34 once inverted
        xfer(48'h640600151194, 48'h640600151194, 6);
        xfer(48'h640300160001, 40'h6403020A06, 5);
        xfer(48'h640300140005, 104'h64030A000000000A060002001E,
            13);
        xfer(48'h6403001E0005, 104'h64030A000000000000000100B4,
            13);
        xfer(48'h64060018002D, 48'h64060018002D, 6);
        xfer(48'h640600321234, 24'h648603, 3);
        `CHK("save pulses", 0, n_save)
        xfer(48'h640600325354, 48'h640600325354, 6);
        `CHK("save pulses", 1, n_save)
        xfer(48'h640600345253, 48'h640600345253, 6);
        `CHK("restart pulses", 1, n_restart)
        `CHK("line rate", 16'h0003, active_rate_code)
        `CHK("parity", 16'h0002, active_parity_code)
        `CHK("stop bits", 16'h0001, active_stop_code)
        xfer(48'h640300030002, 120'h0, 0);
        xfer(48'h2003000A0006, 120'h20030C00030002000100200001012C,
            15);
        u_m.corrupt = 1'b1;
        xfer(48'h2003000A0006, 120'h0, 0);
        u_m.corrupt = 1'b0;
        @(negedge clk) raw_angle_x = 16'hF540;
        sensor_fault = 1'b1;
        stall = 1'b1;
        xfer(48'h200300030004, 88'h200308119414C6001C0403, 11);
        wrap_up();
    end
endmodule // tilt_modbus_server_tb
bind tilt_modbus_server tilt_server_props u_props (.clk(clk), .reset(reset),
    .single_axis(single_axis), .raw_angle_x(raw_angle_x),
    .raw_angle_y(raw_angle_y), .temp_celsius(temp_celsius),
    .sensor_fault(sensor_fault), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .bit_tick(bit_tick), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .active_rate_code(active_rate_code),
    .active_parity_code(active_parity_code),
    .active_stop_code(active_stop_code), .save_pulse(save_pulse),
    .restart_pulse(restart_pulse));
